// ===== hw/bpc_ctrl.v
// What this block does
// - slave controller keeps receiver enabled and driver disabled for detection
// - bus traffic holds no run of equal bits longer than minimum failsafe time
// - master idles bus, direction low, longer than maximum failsafe time first
// - after power-up slave controller actively drives direction low to listen
// - signalling rate never exceeds 250 kbps
`include "bpc_map.vh"

module bpc_ctrl #(
   parameter [31:0] SETTLE_CYCLES = `BPC_FS_MAX_US * `BPC_CLK_MHZ + 1,
   parameter [31:0] BIT_CYCLES = 32'h0000_01f4,
   parameter [31:0] BIT_MAX_CYCLES = `BPC_BIT_MAX_NS / `BPC_NS_PER_US * `BPC_CLK_MHZ
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_tx_valid,
   input wire [`BPC_DATA_BITS-1:0] i_tx_data,
   output wire o_tx_ready,
   input wire i_standby_req,
   output reg [`BPC_DATA_BITS-1:0] o_rx_data,
   output reg o_rx_valid,
   output reg o_rx_frame_err,
   output reg o_settled,
   output reg o_standby,
   output reg o_driver_output_enable,
   output reg o_receiver_output_enable_n,
   output reg o_txd,
   input wire i_rxd
);
   function [31:0] ns_to_cyc_up;
      input [31:0] ns;
      reg [31:0] c;
      begin
         c = (ns * `BPC_CLK_MHZ + `BPC_NS_PER_US - 1) / `BPC_NS_PER_US;
         ns_to_cyc_up = (c == `BPC_CNT_ZERO) ? `BPC_CNT_ONE : c;
      end
   endfunction

   localparam [31:0] STBY_MIN_CYC = ns_to_cyc_up(`BPC_STBY_MIN_NS);
   localparam [31:0] DRV_EN_CYC = ns_to_cyc_up(`BPC_DRV_EN_NS);
   localparam [31:0] RCV_EN_CYC = ns_to_cyc_up(`BPC_RCV_EN_NS);
   localparam [31:0] BIT_MIN_CYC = ns_to_cyc_up(`BPC_BIT_MIN_NS);
   // bit time clamped: fast enough end keeps rate legal, slow end keeps runs short
   localparam [31:0] BIT_USE = (BIT_CYCLES < BIT_MIN_CYC) ? BIT_MIN_CYC :
                               (BIT_CYCLES > BIT_MAX_CYCLES) ? BIT_MAX_CYCLES : BIT_CYCLES;

   localparam [5:0] ST_SETTLE = 6'h01;
   localparam [5:0] ST_IDLE = 6'h02;
   localparam [5:0] ST_STBY = 6'h04;
   localparam [5:0] ST_WAKE = 6'h08;
   localparam [5:0] ST_DEN = 6'h10;
   localparam [5:0] ST_TX = 6'h20;
   localparam [3:0] LAST_FRAME_BIT = `BPC_FRAME_BITS - 1;

   reg [5:0] state;
   reg [5:0] next_state;
   reg [`BPC_CNT_W-1:0] cnt;
   reg [3:0] bit_idx;
   reg [`BPC_FRAME_BITS-1:0] shift;
   reg rxd_meta;
   reg rxd_sync;
   reg rx_en;
   wire cnt_hit_settle = (cnt == SETTLE_CYCLES - `BPC_CNT_ONE);
   wire cnt_hit_bit = (cnt == BIT_USE - `BPC_CNT_ONE);
   wire [`BPC_DATA_BITS-1:0] rx_data;
   wire rx_valid;
   wire rx_err;

   assign o_tx_ready = (state == ST_IDLE) && !i_standby_req;

   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rxd_meta <= `BPC_LINE_IDLE;
         rxd_sync <= `BPC_LINE_IDLE;
      end else begin
         rxd_meta <= i_rxd;
         rxd_sync <= rxd_meta;
      end
   end

   always @* begin
      next_state = state;
      case (state)
         ST_SETTLE: begin
            // listen on an idle bus past the longest failsafe time
            if (cnt_hit_settle)
               next_state = ST_IDLE;
         end
         ST_IDLE: begin
            if (i_tx_valid)
               next_state = ST_DEN;
            else if (i_standby_req)
               next_state = ST_STBY;
         end
         ST_STBY: begin
            // dwell long enough that the device really powers down
            if (!i_standby_req && cnt >= STBY_MIN_CYC - `BPC_CNT_ONE)
               next_state = ST_WAKE;
         end
         ST_WAKE: begin
            if (cnt == RCV_EN_CYC - `BPC_CNT_ONE)
               next_state = ST_IDLE;
         end
         ST_DEN: begin
            if (cnt == DRV_EN_CYC - `BPC_CNT_ONE)
               next_state = ST_TX;
         end
         ST_TX: begin
            // driver released after every frame so no driven run outlasts one frame
            if (cnt_hit_bit && bit_idx == LAST_FRAME_BIT)
               next_state = ST_IDLE;
         end
         default: next_state = ST_SETTLE;
      endcase
   end

   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= ST_SETTLE;
         cnt <= `BPC_CNT_ZERO;
         bit_idx <= 4'h0;
         shift <= {`BPC_FRAME_BITS{`BPC_LINE_IDLE}};
         o_txd <= `BPC_LINE_IDLE;
         // listening from reset: driver off, receiver on
         o_driver_output_enable <= 1'b0;
         o_receiver_output_enable_n <= 1'b0;
         o_settled <= 1'b0;
         o_standby <= 1'b0;
         rx_en <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state != state)
            cnt <= `BPC_CNT_ZERO;
         else if (state == ST_TX && cnt_hit_bit)
            cnt <= `BPC_CNT_ZERO;
         else if (state != ST_IDLE && cnt != {`BPC_CNT_W{1'b1}})
            cnt <= cnt + `BPC_CNT_ONE;
         if (state == ST_IDLE && next_state == ST_DEN) begin
            shift <= {`BPC_LINE_IDLE, i_tx_data, `BPC_LINE_START};
            bit_idx <= 4'h0;
         end else if (state == ST_TX && cnt_hit_bit) begin
            shift <= {`BPC_LINE_IDLE, shift[`BPC_FRAME_BITS-1:1]};
            bit_idx <= bit_idx + 4'h1;
         end
         // each bit held BIT_USE cycles, never under 4 us
         o_txd <= (next_state == ST_TX) ? ((state == ST_TX && cnt_hit_bit) ?
                  shift[1] : shift[0]) : `BPC_LINE_IDLE;
         // enables change one at a time, never both disabled in passing
         o_driver_output_enable <= (next_state == ST_DEN) || (next_state == ST_TX);
         o_receiver_output_enable_n <= (next_state == ST_STBY);
         o_standby <= (next_state == ST_STBY);
         if (next_state == ST_IDLE)
            o_settled <= 1'b1;
         rx_en <= (next_state == ST_IDLE);
      end
   end

   // the transceiver corrects polarity itself, so data passes uninverted here
   bpc_uart_rx #(
      .BIT_CYCLES(BIT_USE)
   ) u_rx (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_enable(rx_en),
      .i_rxd(rxd_sync),
      .o_data(rx_data),
      .o_valid(rx_valid),
      .o_frame_err(rx_err)
   );

   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rx_data <= {`BPC_DATA_BITS{1'b0}};
         o_rx_valid <= 1'b0;
         o_rx_frame_err <= 1'b0;
      end else begin
         o_rx_valid <= rx_valid;
         o_rx_frame_err <= rx_err;
         if (rx_valid)
            o_rx_data <= rx_data;
      end
   end
endmodule

// ===== hw/bpc_map.vh
`ifndef BPC_MAP_VH
`define BPC_MAP_VH

// clock rate in MHz
`define BPC_CLK_MHZ 125
// longest failsafe idle time of the transceiver, in microseconds
`define BPC_FS_MAX_US 76000
// least time the enables stay disabled before standby is reached
`define BPC_STBY_MIN_NS 300
// driver enable time with receiver enabled
`define BPC_DRV_EN_NS 1000
// receiver enable time with driver disabled
`define BPC_RCV_EN_NS 8000
// shortest bit time, i.e. 250 kbps
`define BPC_BIT_MIN_NS 4000
// longest bit time
`define BPC_BIT_MAX_NS 3300000
// frame layout: start, eight data, stop
`define BPC_DATA_BITS 8
`define BPC_FRAME_BITS 10
`define BPC_LINE_IDLE 1'h1
`define BPC_LINE_START 1'h0
// counter width and common counter values
`define BPC_CNT_W 32
`define BPC_CNT_ZERO 32'h0000_0000
`define BPC_CNT_ONE 32'h0000_0001
`define BPC_NS_PER_US 1000

`endif

// ===== hw/bpc_uart_rx.v
`include "bpc_map.vh"

module bpc_uart_rx #(
   parameter [31:0] BIT_CYCLES = 32'h0000_01f4
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_enable,
   input wire i_rxd,
   output reg [`BPC_DATA_BITS-1:0] o_data,
   output reg o_valid,
   output reg o_frame_err
);
   localparam [3:0] R_IDLE = 4'h1;
   localparam [3:0] R_START = 4'h2;
   localparam [3:0] R_DATA = 4'h4;
   localparam [3:0] R_STOP = 4'h8;
   localparam [31:0] HALF_BIT = BIT_CYCLES >> 1;
   localparam [3:0] LAST_BIT = `BPC_DATA_BITS - 1;

   reg [3:0] state;
   reg [`BPC_CNT_W-1:0] cnt;
   reg [3:0] bit_idx;
   reg [`BPC_DATA_BITS-1:0] shift;

   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= R_IDLE;
         cnt <= `BPC_CNT_ZERO;
         bit_idx <= 4'h0;
         shift <= {`BPC_DATA_BITS{1'b0}};
         o_data <= {`BPC_DATA_BITS{1'b0}};
         o_valid <= 1'b0;
         o_frame_err <= 1'b0;
      end else begin
         o_valid <= 1'b0;
         o_frame_err <= 1'b0;
         if (!i_enable) begin
            // own echo and standby noise are dropped, frame restarts on enable
            state <= R_IDLE;
            cnt <= `BPC_CNT_ZERO;
         end else begin
            case (state)
               R_IDLE: begin
                  cnt <= `BPC_CNT_ZERO;
                  if (i_rxd == `BPC_LINE_START)
                     state <= R_START;
               end
               R_START: begin
                  if (i_rxd != `BPC_LINE_START) begin
                     state <= R_IDLE;
                  end else if (cnt == HALF_BIT) begin
                     cnt <= `BPC_CNT_ZERO;
                     bit_idx <= 4'h0;
                     state <= R_DATA;
                  end else begin
                     cnt <= cnt + `BPC_CNT_ONE;
                  end
               end
               R_DATA: begin
                  if (cnt == BIT_CYCLES - `BPC_CNT_ONE) begin
                     cnt <= `BPC_CNT_ZERO;
                     shift <= {i_rxd, shift[`BPC_DATA_BITS-1:1]};
                     if (bit_idx == LAST_BIT)
                        state <= R_STOP;
                     else
                        bit_idx <= bit_idx + 4'h1;
                  end else begin
                     cnt <= cnt + `BPC_CNT_ONE;
                  end
               end
               R_STOP: begin
                  if (cnt == BIT_CYCLES - `BPC_CNT_ONE) begin
                     cnt <= `BPC_CNT_ZERO;
                     state <= R_IDLE;
                     if (i_rxd == `BPC_LINE_IDLE) begin
                        o_data <= shift;
                        o_valid <= 1'b1;
                     end else begin
                        o_frame_err <= 1'b1;
                     end
                  end else begin
                     cnt <= cnt + `BPC_CNT_ONE;
                  end
               end
               default: state <= R_IDLE;
            endcase
         end
      end
   end
endmodule

// ===== dv/bpc_ctrl_properties.sv
module bpc_ctrl_props #(
   parameter [31:0] SETTLE_CYCLES = 32'h0000_00c8,
   parameter [31:0] BIT_CYCLES = 32'h0000_01f4
) (
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_tx_valid,
   input wire o_tx_ready,
   input wire i_standby_req,
   input wire o_settled,
   input wire o_standby,
   input wire o_driver_output_enable,
   input wire o_receiver_output_enable_n,
   input wire o_txd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] de_cnt;
   logic [31:0] sb_cnt;
   logic [31:0] st_cnt;
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         de_cnt <= 32'h0000_0000;
         sb_cnt <= 32'h0000_0000;
         st_cnt <= 32'h0000_0000;
      end else begin
         de_cnt <= o_driver_output_enable ? de_cnt + 32'h0000_0001 : 32'h0000_0000;
         sb_cnt <= o_standby ? sb_cnt + 32'h0000_0001 : 32'h0000_0000;
         st_cnt <= o_settled ? st_cnt : st_cnt + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   a_settle_listen: assert property (!o_settled |->
      !o_driver_output_enable && !o_receiver_output_enable_n) else $error("enable during settle");
   a_settle_time: assert property ($rose(o_settled) |-> st_cnt >= SETTLE_CYCLES - 32'h1)
      else $error("settle too short");
   a_stby_enables: assert property (o_standby |->
      !o_driver_output_enable && o_receiver_output_enable_n) else $error("standby enables");
   a_stby_hold: assert property ($fell(o_standby) |-> sb_cnt >= 32'h0000_0026)
      else $error("standby left early");
   a_wake_prompt: assert property (o_standby && !i_standby_req && sb_cnt >= 32'h0000_0026
      |-> ##[1:2] !o_receiver_output_enable_n) else $error("wake late");
   a_one_enable_edge: assert property (!($changed(o_driver_output_enable) &&
      $changed(o_receiver_output_enable_n))) else $error("both enables changed");
   a_tx_take: assert property (i_tx_valid && o_tx_ready |=>
      o_driver_output_enable && !o_tx_ready) else $error("tx not taken");
   a_start_gap: assert property ($rose(o_driver_output_enable) |-> ##124 o_txd ##1 !o_txd)
      else $error("start bit gap");
   a_frame_len: assert property ($fell(o_driver_output_enable) |->
      de_cnt == 32'h0000_000a * BIT_CYCLES + 32'h0000_007d) else $error("frame length");
   c_tx: cover property ($fell(o_driver_output_enable));
   c_stby: cover property ($fell(o_standby));
   c_settle: cover property ($rose(o_settled));
endmodule

// ===== dv/bpc_xcvr_model.sv
module bpc_xcvr_model #(
   parameter [31:0] FS_CYCLES = 32'h0000_0096
) (
   input wire i_mclk,
   input wire i_pwr_rst,
   input wire i_de,
   input wire i_re_n,
   input wire i_txd,
   input wire i_line,
   output wire o_rxd,
   output wire o_bus,
   output reg o_stby
);
   timeunit 1ns;
   timeprecision 1ps;
   reg inv;
   reg rx_last;
   reg [31:0] fs_cnt;
   reg [31:0] dis_cnt;
   // polarity decision is redone on every power-up
   always @(posedge i_mclk or posedge i_pwr_rst) begin
      if (i_pwr_rst) begin
         inv <= 1'h0;
         rx_last <= 1'h1;
         fs_cnt <= 32'h0000_0000;
         dis_cnt <= 32'h0000_0000;
         o_stby <= 1'h0;
      end else begin
         fs_cnt <= (!i_de && !i_re_n && !i_line) ? fs_cnt + 32'h1 : 32'h0;
         if (fs_cnt >= FS_CYCLES) inv <= 1'h1;
         dis_cnt <= (!i_de && i_re_n) ? dis_cnt + 32'h1 : 32'h0;
         o_stby <= !i_de && i_re_n && dis_cnt >= 32'h0000_0025;
         if (!i_re_n) rx_last <= o_rxd;
      end
   end
   // released output shows the inverse of its last level, not a hold
   assign o_rxd = i_re_n ? ~rx_last : i_line ^ inv;
   assign o_bus = i_txd ^ inv;
endmodule

// ===== dv/bpc_ctrl_tb.sv
module bpc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [31:0] SETTLE = 32'h0000_00c8;
   localparam [31:0] BIT = 32'h0000_01f4;
   reg i_mclk, i_sys_rst, i_tx_valid, i_standby_req, m_line;
   reg [7:0] i_tx_data;
   wire [7:0] o_rx_data;
   wire o_tx_ready, o_rx_valid, o_rx_frame_err, o_settled, o_standby;
   wire o_driver_output_enable, o_receiver_output_enable_n, o_txd, x_rxd, x_bus, x_stby;
   // pair is cross-wired between master and slave
   wire s_line = o_driver_output_enable ? x_bus : ~m_line;
   wire m_seen = ~s_line;
   integer miscompares, num_checks, n, i;
   reg [7:0] got;
   bpc_ctrl #(.SETTLE_CYCLES(SETTLE), .BIT_CYCLES(BIT)) i_bpc_ctrl (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
      .o_tx_ready(o_tx_ready), .i_standby_req(i_standby_req), .o_rx_data(o_rx_data),
      .o_rx_valid(o_rx_valid), .o_rx_frame_err(o_rx_frame_err), .o_settled(o_settled),
      .o_standby(o_standby), .o_driver_output_enable(o_driver_output_enable),
      .o_receiver_output_enable_n(o_receiver_output_enable_n), .o_txd(o_txd), .i_rxd(x_rxd));
   bpc_xcvr_model i_bpc_xcvr_model (.i_mclk(i_mclk), .i_pwr_rst(i_sys_rst),
      .i_de(o_driver_output_enable), .i_re_n(o_receiver_output_enable_n), .i_txd(o_txd),
      .i_line(s_line), .o_rxd(x_rxd), .o_bus(x_bus), .o_stby(x_stby));
   task chk(input [7:0] exp, input [7:0] act);
      num_checks = num_checks + 1;
      if (act !== exp) begin
         miscompares = miscompares + 1;
         $display("Error at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task t_settle;
      chk({6'h00, o_driver_output_enable, o_receiver_output_enable_n}, 8'h00);
      chk({7'h00, o_tx_ready}, 8'h00);
      for (n = 0; n < 300 && o_settled !== 1'h1; n++) @(negedge i_mclk);
      chk({7'h00, o_settled}, 8'h01);
      chk({7'h00, x_rxd}, 8'h01);
      $display("settle test done");
   endtask
   task t_rx(input [7:0] b);
      for (i = 0; i < 9; i++) begin
         m_line = (i == 0) ? 1'h0 : b[i-1];
         repeat (BIT) @(negedge i_mclk);
      end
      m_line = 1'h1;
      for (n = 0; n < 1000 && o_rx_valid !== 1'h1; n++) @(negedge i_mclk);
      chk(o_rx_data, b);
      repeat (BIT) @(negedge i_mclk);
      $display("rx test done");
   endtask
   task t_tx(input [7:0] b);
      i_tx_valid = 1'h1;
      i_tx_data = b;
      for (n = 0; n < 2 * BIT && o_tx_ready !== 1'h1; n++) @(negedge i_mclk);
      @(negedge i_mclk);
      i_tx_valid = 1'h0;
      for (n = 0; n < 200 && o_txd !== 1'h0; n++) @(negedge i_mclk);
      repeat (BIT / 2) @(negedge i_mclk);
      chk({7'h00, o_tx_ready}, 8'h00);
      for (i = 0; i < 8; i++) begin
         repeat (BIT) @(negedge i_mclk);
         got[i] = m_seen;
      end
      chk(got, b);
      repeat (BIT) @(negedge i_mclk);
      chk({7'h00, m_seen}, 8'h01);
      for (n = 0; n < BIT && o_tx_ready !== 1'h1; n++) @(negedge i_mclk);
      $display("tx test done");
   endtask
   task t_stby(input integer hold);
      i_standby_req = 1'h1;
      repeat (hold) @(negedge i_mclk);
      chk({6'h00, o_standby, o_receiver_output_enable_n}, 8'h03);
      chk({7'h00, hold > 40 ? x_stby : o_standby}, 8'h01);
      i_standby_req = 1'h0;
      repeat (2) @(negedge i_mclk);
      chk({7'h00, o_standby}, {7'h00, hold < 38});
      for (n = 0; n < 50 && o_receiver_output_enable_n !== 1'h0; n++) @(negedge i_mclk);
      @(negedge i_mclk);
      chk({7'h00, x_stby}, 8'h00);
      for (n = 0; n < 1100 && o_tx_ready !== 1'h1; n++) @(negedge i_mclk);
      chk({7'h00, o_tx_ready}, 8'h01);
      $display("standby test done");
   endtask
   initial begin
      i_mclk = 1'h0;
      forever #4 i_mclk = ~i_mclk;
   end
   initial begin
      repeat (40000) @(posedge i_mclk);
      miscompares = miscompares + 1;
      report_and_stop;
   end
   initial begin
      miscompares = 0;
      num_checks = 0;
      {i_sys_rst, m_line, i_tx_valid, i_standby_req, i_tx_data} = 12'h c00;
      repeat (6) @(negedge i_mclk);
      i_sys_rst = 1'h0;
      @(negedge i_mclk);
      t_settle;
      t_rx(8'h5a);
      t_rx(8'h81);
      t_tx(8'hc3);
      t_tx(8'h01);
      t_stby(45);
      t_stby(3);
      report_and_stop;
   end
endmodule
bind bpc_ctrl bpc_ctrl_props #(.SETTLE_CYCLES(SETTLE_CYCLES), .BIT_CYCLES(BIT_CYCLES))
   i_bpc_ctrl_props (.i_mclk, .i_sys_rst, .i_tx_valid, .o_tx_ready, .i_standby_req, .o_settled,
   .o_standby, .o_driver_output_enable, .o_receiver_output_enable_n, .o_txd);
